// >>> dv/periph_model.sv
// Peripheral model: strobes data in and acknowledges data out
`default_nettype none
module periph_model (
	input wire logic pclk,
	output logic [7:0] pa_in,
	output logic [7:0] pb_in,
	output logic [7:0] pc_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic stb_n = 1'b1;
	logic ack_n = 1'b1;
	logic [7:0] gen = 8'hFF;
	////////////////////////////////////////////////////////////////////////////
	// Handshake inputs idle high; free lines show the general pattern
	always_comb begin
		pc_in = gen;
		pc_in[ppi_pkg::PC_STROBE_A] = stb_n;
		pc_in[ppi_pkg::PC_ACK_A] = ack_n;
	end
	initial begin
		pa_in = 8'h5A;
		pb_in = 8'h3C;
	end
	// Strobe in one byte, then release the bus to the inverse value
	task automatic strobe(input logic [7:0] d);
		@(posedge pclk);
		pa_in <= d;
		stb_n <= 1'b0;
		repeat (3) @(posedge pclk);
		stb_n <= 1'b1;
		@(posedge pclk);
		pa_in <= ~d;
	endtask
	// Acknowledge output data with a three-cycle low pulse
	task automatic ack();
		@(posedge pclk);
		ack_n <= 1'b0;
		repeat (3) @(posedge pclk);
		ack_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> dv/port_c_ctrl_chk.sv
// Checker of bus timing, pin direction and handshake flags of the third port
`default_nettype none
module port_c_ctrl_chk #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] pa_in,
	input wire logic [7:0] pa_out,
	input wire logic [7:0] pa_oe_n,
	input wire logic [7:0] pb_in,
	input wire logic [7:0] pb_out,
	input wire logic [7:0] pb_oe_n,
	input wire logic [7:0] pc_in,
	input wire logic [7:0] pc_out,
	input wire logic [7:0] pc_oe_n,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////
	// Mode and bit command tracked from committed writes
	ppi_pkg::mode_t mode_r;
	logic [1:0] age_r;
	logic [2:0] line_r;
	logic val_r;
	logic wr_go, bsr_go, basic, a_in, a_out, tgt_in;
	assign wr_go = ce && psel && penable && pready && pwrite;
	assign bsr_go = wr_go && paddr[7:0] == ppi_pkg::OFF_BITSR;
	assign basic = age_r == 2'h3 && mode_r.a_mode == ppi_pkg::A_MODE_BASIC && !mode_r.b_strobed;
	assign a_in = age_r == 2'h3 && (mode_r.a_mode[1] || mode_r.a_mode[0] && mode_r.a_port_input);
	assign a_out = age_r == 2'h3 && (mode_r.a_mode[1] || mode_r.a_mode[0] && !mode_r.a_port_input);
	assign tgt_in = pwdata[3] ? mode_r.cu_input : mode_r.cl_input;
	// Settling age counts edges since the last mode change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= ppi_pkg::MODE_RST;
			age_r <= 2'h3;
			line_r <= 3'h0;
			val_r <= 1'b0;
		end else begin
			if (wr_go && paddr[7:0] == ppi_pkg::OFF_MODE) begin
				mode_r <= ppi_pkg::mode_t'(pwdata[6:0]);
				age_r <= 2'h0;
			end else if (age_r != 2'h3) begin
				age_r <= age_r + 2'h1;
			end
			if (bsr_go) begin
				line_r <= pwdata[3:1];
				val_r <= pwdata[0];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Assertions
	ready_after_access_a:
	assert property (ce && psel && penable && !pready |=> pready) else $error("ready late");
	ready_pulse_a:
	assert property (pready && ce |=> !pready) else $error("ready held too long");
	err_with_ready_a:
	assert property (pslverr |-> pready) else $error("error without ready");
	free_line_dir_a:
	assert property (basic |-> pc_oe_n == {{4{mode_r.cu_input}}, {4{mode_r.cl_input}}})
		else $error("free line direction wrong");
	bit_cmd_out_a:
	assert property (bsr_go && basic && !tgt_in |-> ##[1:3] pc_out[line_r] == val_r)
		else $error("bit command missed output");
	input_kept_a:
	assert property (bsr_go && basic && tgt_in |=> $stable({pc_oe_n, pc_out}) [*3])
		else $error("bit command changed input line");
	in_full_set_a:
	assert property ((ce && a_in && !pc_in[4]) [*3] |=> pc_out[5])
		else $error("input full not set");
	out_full_rel_a:
	assert property ((ce && a_out && !pc_in[6]) [*3] |=> pc_out[7])
		else $error("output full held");
	ce_freeze_a:
	assert property (!ce |=> $stable({pc_out, pc_oe_n, pa_out, pa_oe_n, irq, pready}))
		else $error("state moved while frozen");
	cover property (bsr_go && basic);
	cover property (pslverr);
	cover property (irq);
endmodule
bind port_c_ctrl port_c_ctrl_chk #(.ADDR_W(ADDR_W)) port_c_ctrl_chk_i (
	.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_in(pb_in), .pb_out(pb_out),
	.pb_oe_n(pb_oe_n), .pc_in(pc_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .irq(irq)
);
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench of the third-port control block
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD %0t got %h expected %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] MD = ppi_pkg::OFF_MODE;
	localparam logic [7:0] PC = ppi_pkg::OFF_PORTC;
	localparam logic [7:0] BS = ppi_pkg::OFF_BITSR;
	localparam logic [7:0] ST = ppi_pkg::OFF_IRQ_STAT;
	localparam logic [7:0] MK = ppi_pkg::OFF_IRQ_MASK;
	localparam logic [7:0] PA = ppi_pkg::OFF_PORTA;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, irq;
	logic [7:0] pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n, pc_in, pc_out, pc_oe_n;
	int bad_count = 0;
	int n_compared = 0;
	always #50 pclk = ~pclk;
	port_c_ctrl port_c_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
		.pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pc_in(pc_in), .pc_out(pc_out),
		.pc_oe_n(pc_oe_n), .irq(irq));
	periph_model periph_model_i (.pclk(pclk), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in));
	////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One bus transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic bsr(input logic [2:0] l, input logic v);
		apb(1'b1, BS, {28'h0, l, v});
	endtask
	task automatic settle();
		repeat (3) @(posedge pclk);
	endtask
	// Expected third-port read with the first group bidirectional, second strobed
	function automatic logic [7:0] exp_flags(input logic [3:0] e);
		return {1'b1, e[2], 1'b0, e[1], e[2], e[0], ~e[3], e[0] & ~e[3]};
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		ppi_pkg::mode_t m;
		logic [7:0] lat, om, pins;
		logic [2:0] l;
		logic v;
		void'($urandom(32'hCED26EC8));
		repeat (6) @(posedge pclk);
		`CHK(pc_oe_n, 8'hFF)
		presetn <= 1'b1;
		apb(1'b0, MD, 32'h0);
		`CHK(rd[6:0], ppi_pkg::MODE_RST)
		apb(1'b0, 8'h1C, 32'h0);
		`CHK(err, 1'b1)
		// Basic mode: random directions, whole-port writes, bit commands
		for (int i = 0; i < 10; i++) begin
			m = 7'($urandom()) & 7'h6C;
			om = ~{{4{m.cu_input}}, {4{m.cl_input}}};
			pins = 8'($urandom()) | 8'h50;
			periph_model_i.gen <= pins;
			apb(1'b1, MD, {25'h0, m});
			lat = 8'($urandom());
			apb(1'b1, PC, {24'h0, lat});
			l = 3'($urandom());
			v = 1'($urandom());
			bsr(l, v);
			if (om[l]) lat[l] = v;
			settle();
			apb(1'b0, PC, 32'h0);
			`CHK(rd[7:0], (lat & om) | (pins & ~om))
			`CHK(pc_out & om, lat & om)
		end
		// Bidirectional first group, strobed second group: every enable pattern
		periph_model_i.gen <= 8'hFF;
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, MD, {25'h0, 1'b0, i[3], 5'h12});
			bsr(3'h2, i[0]);
			bsr(3'h4, i[1]);
			bsr(3'h6, i[2]);
			apb(1'b1, PC, {24'h0, 8'($urandom())});
			apb(1'b0, PC, 32'h0);
			`CHK(rd[7:0], exp_flags(4'(i)))
		end
		// Forced flags hold until the next handshake event
		apb(1'b1, MD, 32'h12);
		apb(1'b1, MK, 32'hF);
		bsr(3'h4, 1'b1);
		bsr(3'h6, 1'b1);
		settle();
		`CHK({irq, pc_out[3]}, 2'h3)
		bsr(3'h3, 1'b0);
		apb(1'b1, ST, 32'hF);
		settle();
		`CHK({irq, pc_out[3]}, 2'h0)
		bsr(3'h5, 1'b1);
		settle();
		`CHK(pc_out[5], 1'b1)
		apb(1'b0, PA, 32'h0);
		settle();
		`CHK({pc_out[5], pc_out[3]}, 2'h0)
		// Strobed input with its interrupt status
		apb(1'b1, ST, 32'hF);
		periph_model_i.strobe(8'hC3);
		settle();
		`CHK({pc_out[5], pc_out[3]}, 2'h3)
		apb(1'b0, ST, 32'h0);
		`CHK({irq, rd[3:0]}, 5'h15)
		apb(1'b0, PA, 32'h0);
		`CHK(rd[7:0], 8'hC3)
		settle();
		`CHK({pc_out[5], pc_out[3]}, 2'h0)
		// Masked event keeps the interrupt low until unmasked
		apb(1'b1, ST, 32'hF);
		apb(1'b1, MK, 32'h0);
		periph_model_i.strobe(8'h3C);
		settle();
		`CHK(irq, 1'b0)
		apb(1'b1, MK, 32'h4);
		settle();
		`CHK(irq, 1'b1)
		apb(1'b1, ST, 32'h4);
		apb(1'b0, PA, 32'h0);
		`CHK(irq, 1'b0)
		// Output side: write, acknowledge, write again
		apb(1'b1, PA, 32'h96);
		settle();
		`CHK({pc_out[7], pc_out[3]}, 2'h0)
		periph_model_i.ack();
		settle();
		`CHK({pc_out[7], pc_out[3]}, 2'h3)
		apb(1'b1, PA, 32'h69);
		settle();
		`CHK({pc_out[7], pc_out[3]}, 2'h0)
		// Data pins and second group output flag
		apb(1'b1, ppi_pkg::OFF_PORTB, 32'hA5);
		settle();
		`CHK({pa_out, pa_oe_n, pb_out, pb_oe_n}, 32'h69FF_A500)
		`CHK(pc_out[1], 1'b0)
		// Frozen clock enable ignores a strobe
		ce <= 1'b0;
		periph_model_i.strobe(8'hA5);
		ce <= 1'b1;
		settle();
		`CHK(pc_out[5], 1'b0)
		apb(1'b0, PA, 32'h0);
		`CHK(rd[7:0], 8'h3C)
		// Reset in mid-run returns every line to input
		presetn <= 1'b0;
		settle();
		`CHK({pc_oe_n, pa_oe_n, pready, irq}, 18'h3FFFC)
		presetn <= 1'b1;
		apb(1'b0, MD, 32'h0);
		`CHK(rd[6:0], ppi_pkg::MODE_RST)
		final_report();
	end
endmodule
`default_nettype wire

// >>> src/handshake_group.sv
// Strobe/acknowledge handshake flags and service request for one port group
`default_nettype none
module handshake_group (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	handshake_if.engine hs
);

	ppi_pkg::hs_state_t st_r;
	ppi_pkg::hs_state_t st_nxt;
	logic in_cond;
	logic out_cond;

	////////////////////////////////////////////////////////////////////////////
	// Service request conditions
	assign in_cond = hs.in_en & hs.strobe_n & st_r.input_latch_full & st_r.in_irq_enable;
	assign out_cond = hs.out_en & hs.ack_n & st_r.output_latch_full_n & st_r.out_irq_enable;

	// Next state: forced values first, handshake events override them
	always_comb begin
		st_nxt = st_r;
		st_nxt.in_cond_q = in_cond;
		st_nxt.out_cond_q = out_cond;
		if (hs.clr) begin
			st_nxt = ppi_pkg::HS_RST;
		end else begin
			case (hs.frc_sel)
				ppi_pkg::FRC_REQ: st_nxt.service_request_out = hs.frc_val;
				ppi_pkg::FRC_IN_FULL: st_nxt.input_latch_full = hs.frc_val;
				ppi_pkg::FRC_OUT_FULL: st_nxt.output_latch_full_n = hs.frc_val;
				ppi_pkg::FRC_IE_IN: st_nxt.in_irq_enable = hs.frc_val;
				ppi_pkg::FRC_IE_OUT: st_nxt.out_irq_enable = hs.frc_val;
				default: st_nxt.service_request_out = st_nxt.service_request_out;
			endcase
			// Input side
			if (hs.in_en) begin
				if (hs.rd_evt) begin
					st_nxt.input_latch_full = 1'b0;
					st_nxt.service_request_out = 1'b0;
				end
				if (!hs.strobe_n) begin
					st_nxt.input_latch_full = 1'b1;
				end
			end
			// Output side
			if (hs.out_en) begin
				if (!hs.ack_n) begin
					st_nxt.output_latch_full_n = 1'b1;
				end
				if (hs.wr_evt) begin
					st_nxt.output_latch_full_n = 1'b0;
					st_nxt.service_request_out = 1'b0;
				end
			end
			// Rising condition sets the request; a set wins over a clear
			if ((in_cond & !st_r.in_cond_q) | (out_cond & !st_r.out_cond_q)) begin
				st_nxt.service_request_out = 1'b1;
			end
		end
	end

	// State register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ppi_pkg::HS_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// Flag outputs
	assign hs.input_latch_full = st_r.input_latch_full;
	assign hs.output_latch_full_n = st_r.output_latch_full_n;
	assign hs.service_request_out = st_r.service_request_out;
	assign hs.in_irq_enable = st_r.in_irq_enable;
	assign hs.out_irq_enable = st_r.out_irq_enable;

endmodule
`default_nettype wire

// >>> src/handshake_if.sv
// Signals between the port controller and one handshake group engine
`default_nettype none
interface handshake_if;
	logic in_en;
	logic out_en;
	logic strobe_n;
	logic ack_n;
	logic rd_evt;
	logic wr_evt;
	logic clr;
	ppi_pkg::frc_t frc_sel;
	logic frc_val;
	logic input_latch_full;
	logic output_latch_full_n;
	logic service_request_out;
	logic in_irq_enable;
	logic out_irq_enable;

	modport ctrl (
		output in_en, out_en, strobe_n, ack_n, rd_evt, wr_evt, clr, frc_sel, frc_val,
		input input_latch_full, output_latch_full_n, service_request_out,
		input in_irq_enable, out_irq_enable
	);
	modport engine (
		input in_en, out_en, strobe_n, ack_n, rd_evt, wr_evt, clr, frc_sel, frc_val,
		output input_latch_full, output_latch_full_n, service_request_out,
		output in_irq_enable, out_irq_enable
	);
endinterface
`default_nettype wire

// >>> src/port_c_ctrl.sv
// Third-port status, whole-port write and bit set/reset control with APB access
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`default_nettype none
module port_c_ctrl #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] pa_in,
	output logic [7:0] pa_out,
	output logic [7:0] pa_oe_n,
	input wire logic [7:0] pb_in,
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe_n,
	input wire logic [7:0] pc_in,
	output logic [7:0] pc_out,
	output logic [7:0] pc_oe_n,
	output logic irq
);

	if (ADDR_W < ppi_pkg::OFF_W) begin : g_bad_addr_w
		$error("ADDR_W too small for the register map");
	end

	localparam int GA = 0;
	localparam int GB = 1;

	typedef struct packed {
		ppi_pkg::apb_state_t ap;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		ppi_pkg::mode_t mode;
		logic [7:0] pc_latch;
		logic [7:0] pa_latch;
		logic [7:0] pb_latch;
		logic [7:0] pa_cap;
		logic [7:0] pb_cap;
		logic [7:0] pa_out;
		logic [7:0] pa_oe_n;
		logic [7:0] pb_out;
		logic [7:0] pb_oe_n;
		logic [7:0] pc_out;
		logic [7:0] pc_oe_n;
		logic [ppi_pkg::IRQ_W-1:0] irq_stat;
		logic [ppi_pkg::IRQ_W-1:0] irq_mask;
		logic [ppi_pkg::IRQ_W-1:0] ev_q;
		logic irq;
	} ctrl_state_t;

	ctrl_state_t st_r;
	ctrl_state_t st_nxt;

	handshake_if hs[2] ();

	////////////////////////////////////////////////////////////////////////////
	// Handshake group engines
	for (genvar g = 0; g < 2; g++) begin : g_grp
		handshake_group u_grp (
			.pclk(pclk),
			.presetn(presetn),
			.ce(ce),
			.hs(hs[g])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Decode of mode, bus commit and line ownership
	logic a_bidir;
	logic a_strobed;
	logic a_basic;
	logic b_basic;
	logic a_in_en;
	logic a_out_en;
	logic b_in_en;
	logic b_out_en;
	logic commit;
	logic wr_c;
	logic rd_c;
	logic [7:0] off;
	logic [7:0] hs_out;
	logic [7:0] hs_in;
	logic [7:0] hs_val;
	logic [7:0] flag;
	logic [7:0] basic_out;
	logic [7:0] wmask;
	logic [7:0] pc_read;
	logic [2:0] bsr_sel;
	logic bsr_val;
	logic bsr_c;
	logic [ppi_pkg::IRQ_W-1:0] ev_now;

	assign a_bidir = st_r.mode.a_mode[ppi_pkg::A_MODE_BIDIR_BIT];
	assign a_strobed = (st_r.mode.a_mode == ppi_pkg::A_MODE_STROBED);
	assign a_basic = (st_r.mode.a_mode == ppi_pkg::A_MODE_BASIC);
	assign b_basic = !st_r.mode.b_strobed;
	assign a_in_en = a_bidir | (a_strobed & st_r.mode.a_port_input);
	assign a_out_en = a_bidir | (a_strobed & !st_r.mode.a_port_input);
	assign b_in_en = st_r.mode.b_strobed & st_r.mode.b_port_input;
	assign b_out_en = st_r.mode.b_strobed & !st_r.mode.b_port_input;
	assign commit = (st_r.ap == ppi_pkg::AP_DONE) & psel & penable;
	assign wr_c = commit & pwrite;
	assign rd_c = commit & !pwrite;
	assign off = paddr[ppi_pkg::OFF_W-1:0];
	assign bsr_c = wr_c & (off == ppi_pkg::OFF_BITSR);
	assign bsr_sel = pwdata[ppi_pkg::BSR_SEL_HI:ppi_pkg::BSR_SEL_LO];
	assign bsr_val = pwdata[ppi_pkg::BSR_VAL];

	// Lines claimed by handshake functions
	always_comb begin
		hs_out = 8'h00;
		hs_in = 8'h00;
		hs_out[ppi_pkg::PC_REQ_B] = st_r.mode.b_strobed;
		hs_out[ppi_pkg::PC_FULL_B] = st_r.mode.b_strobed;
		hs_in[ppi_pkg::PC_STROBE_ACK_B] = st_r.mode.b_strobed;
		hs_out[ppi_pkg::PC_REQ_A] = !a_basic;
		hs_out[ppi_pkg::PC_IN_FULL_A] = a_in_en;
		hs_in[ppi_pkg::PC_STROBE_A] = a_in_en;
		hs_out[ppi_pkg::PC_OUT_FULL_A] = a_out_en;
		hs_in[ppi_pkg::PC_ACK_A] = a_out_en;
		hs_val = 8'h00;
		hs_val[ppi_pkg::PC_REQ_B] = hs[GB].service_request_out;
		hs_val[ppi_pkg::PC_FULL_B] = st_r.mode.b_port_input ? hs[GB].input_latch_full
			: hs[GB].output_latch_full_n;
		hs_val[ppi_pkg::PC_REQ_A] = hs[GA].service_request_out;
		hs_val[ppi_pkg::PC_IN_FULL_A] = hs[GA].input_latch_full;
		hs_val[ppi_pkg::PC_OUT_FULL_A] = hs[GA].output_latch_full_n;
		flag = 8'h00;
		flag[ppi_pkg::PC_STROBE_ACK_B] = st_r.mode.b_port_input ? hs[GB].in_irq_enable
			: hs[GB].out_irq_enable;
		flag[ppi_pkg::PC_STROBE_A] = hs[GA].in_irq_enable;
		flag[ppi_pkg::PC_ACK_A] = hs[GA].out_irq_enable;
	end

	// Basic lines take their direction from the mode register
	assign basic_out = {{4{!st_r.mode.cu_input}}, {4{!st_r.mode.cl_input}}} & ~hs_out & ~hs_in;
	// Only basic-group outputs accept a whole-port write
	assign wmask = basic_out & {{4{a_basic}}, a_basic & b_basic, {3{b_basic}}};
	// Live lines, with flag status at strobe/acknowledge positions
	assign pc_read = (hs_in & flag)
		| (~hs_in & ((~st_r.pc_oe_n & st_r.pc_out) | (st_r.pc_oe_n & pc_in)));

	////////////////////////////////////////////////////////////////////////////
	// Requests to the handshake engines
	always_comb begin
		hs[GA].in_en = a_in_en;
		hs[GA].out_en = a_out_en;
		hs[GA].strobe_n = pc_in[ppi_pkg::PC_STROBE_A];
		hs[GA].ack_n = pc_in[ppi_pkg::PC_ACK_A];
		hs[GA].rd_evt = rd_c & (off == ppi_pkg::OFF_PORTA);
		hs[GA].wr_evt = wr_c & (off == ppi_pkg::OFF_PORTA);
		hs[GA].clr = wr_c & (off == ppi_pkg::OFF_MODE);
		hs[GA].frc_val = bsr_val;
		hs[GA].frc_sel = ppi_pkg::FRC_NONE;
		hs[GB].in_en = b_in_en;
		hs[GB].out_en = b_out_en;
		hs[GB].strobe_n = pc_in[ppi_pkg::PC_STROBE_ACK_B];
		hs[GB].ack_n = pc_in[ppi_pkg::PC_STROBE_ACK_B];
		hs[GB].rd_evt = rd_c & (off == ppi_pkg::OFF_PORTB);
		hs[GB].wr_evt = wr_c & (off == ppi_pkg::OFF_PORTB);
		hs[GB].clr = hs[GA].clr;
		hs[GB].frc_val = bsr_val;
		hs[GB].frc_sel = ppi_pkg::FRC_NONE;
		// Bit command on a claimed line goes to the owning engine
		if (bsr_c & (hs_in[bsr_sel] | hs_out[bsr_sel])) begin
			case (bsr_sel)
				3'(ppi_pkg::PC_REQ_B): hs[GB].frc_sel = ppi_pkg::FRC_REQ;
				3'(ppi_pkg::PC_FULL_B): hs[GB].frc_sel = st_r.mode.b_port_input
					? ppi_pkg::FRC_IN_FULL : ppi_pkg::FRC_OUT_FULL;
				3'(ppi_pkg::PC_STROBE_ACK_B): hs[GB].frc_sel = st_r.mode.b_port_input
					? ppi_pkg::FRC_IE_IN : ppi_pkg::FRC_IE_OUT;
				3'(ppi_pkg::PC_REQ_A): hs[GA].frc_sel = ppi_pkg::FRC_REQ;
				3'(ppi_pkg::PC_STROBE_A): hs[GA].frc_sel = ppi_pkg::FRC_IE_IN;
				3'(ppi_pkg::PC_IN_FULL_A): hs[GA].frc_sel = ppi_pkg::FRC_IN_FULL;
				3'(ppi_pkg::PC_ACK_A): hs[GA].frc_sel = ppi_pkg::FRC_IE_OUT;
				3'(ppi_pkg::PC_OUT_FULL_A): hs[GA].frc_sel = ppi_pkg::FRC_OUT_FULL;
				default: hs[GA].frc_sel = ppi_pkg::FRC_NONE;
			endcase
		end
	end

	// Event sources for the sticky status bits
	assign ev_now = {hs[GB].input_latch_full, hs[GA].input_latch_full,
		hs[GB].service_request_out, hs[GA].service_request_out};

	////////////////////////////////////////////////////////////////////////////
	// Next state: bus slave, latches, pins and interrupt
	always_comb begin
		st_nxt = st_r;
		st_nxt.ev_q = ev_now;
		// Bus slave: one wait state, answer from a flop
		case (st_r.ap)
			ppi_pkg::AP_IDLE: begin
				if (psel & penable) begin
					st_nxt.ap = ppi_pkg::AP_DONE;
					st_nxt.pready = 1'b1;
					st_nxt.pslverr = 1'b0;
					st_nxt.prdata = 32'h0000_0000;
					case (off)
						ppi_pkg::OFF_MODE: st_nxt.prdata = 32'(st_r.mode);
						ppi_pkg::OFF_PORTC: st_nxt.prdata = 32'(pc_read);
						ppi_pkg::OFF_BITSR: st_nxt.prdata = 32'h0000_0000;
						ppi_pkg::OFF_IRQ_STAT: st_nxt.prdata = 32'(st_r.irq_stat);
						ppi_pkg::OFF_IRQ_MASK: st_nxt.prdata = 32'(st_r.irq_mask);
						ppi_pkg::OFF_PORTA: st_nxt.prdata = 32'(a_in_en ? st_r.pa_cap
							: ((a_basic & st_r.mode.a_port_input) ? pa_in : st_r.pa_latch));
						ppi_pkg::OFF_PORTB: st_nxt.prdata = 32'(b_in_en ? st_r.pb_cap
							: ((b_basic & st_r.mode.b_port_input) ? pb_in : st_r.pb_latch));
						default: st_nxt.pslverr = 1'b1;
					endcase
				end
			end
			ppi_pkg::AP_DONE: begin
				st_nxt.ap = ppi_pkg::AP_IDLE;
				st_nxt.pready = 1'b0;
				st_nxt.pslverr = 1'b0;
			end
			default: st_nxt.ap = ppi_pkg::AP_IDLE;
		endcase
		// Register writes take effect at the completing edge
		if (wr_c) begin
			case (off)
				ppi_pkg::OFF_MODE: begin
					st_nxt.mode = ppi_pkg::mode_t'(pwdata[ppi_pkg::MODE_W-1:0]);
					st_nxt.pc_latch = 8'h00;
				end
				ppi_pkg::OFF_PORTC: st_nxt.pc_latch = (st_r.pc_latch & ~wmask)
					| (pwdata[7:0] & wmask);
				ppi_pkg::OFF_IRQ_MASK: st_nxt.irq_mask = pwdata[ppi_pkg::IRQ_W-1:0];
				ppi_pkg::OFF_IRQ_STAT: st_nxt.irq_stat = st_r.irq_stat
					& ~pwdata[ppi_pkg::IRQ_W-1:0];
				ppi_pkg::OFF_PORTA: st_nxt.pa_latch = pwdata[7:0];
				ppi_pkg::OFF_PORTB: st_nxt.pb_latch = pwdata[7:0];
				default: st_nxt.pc_latch = st_nxt.pc_latch;
			endcase
		end
		// Bit command on a free output line; input lines stay as they are
		if (bsr_c & basic_out[bsr_sel]) begin
			st_nxt.pc_latch[bsr_sel] = bsr_val;
		end
		// Strobed input capture while the strobe is low
		if (a_in_en & !pc_in[ppi_pkg::PC_STROBE_A]) begin
			st_nxt.pa_cap = pa_in;
		end
		if (b_in_en & !pc_in[ppi_pkg::PC_STROBE_ACK_B]) begin
			st_nxt.pb_cap = pb_in;
		end
		// Pin drive
		st_nxt.pc_out = (hs_out & hs_val) | (~hs_out & st_nxt.pc_latch);
		st_nxt.pc_oe_n = ~(hs_out | basic_out);
		st_nxt.pa_out = st_nxt.pa_latch;
		st_nxt.pa_oe_n = a_bidir ? {8{pc_in[ppi_pkg::PC_ACK_A]}}
			: {8{st_r.mode.a_port_input}};
		st_nxt.pb_out = st_nxt.pb_latch;
		st_nxt.pb_oe_n = {8{st_r.mode.b_port_input}};
		// Sticky events; a new event wins over a clear
		st_nxt.irq_stat = st_nxt.irq_stat | (ev_now & ~st_r.ev_q);
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
	end

	// State register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{ap: ppi_pkg::AP_IDLE, mode: ppi_pkg::MODE_RST, pc_oe_n: 8'hFF,
				pa_oe_n: 8'hFF, pb_oe_n: 8'hFF, default: '0};
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign pa_out = st_r.pa_out;
	assign pa_oe_n = st_r.pa_oe_n;
	assign pb_out = st_r.pb_out;
	assign pb_oe_n = st_r.pb_oe_n;
	assign pc_out = st_r.pc_out;
	assign pc_oe_n = st_r.pc_oe_n;
	assign irq = st_r.irq;

endmodule
`default_nettype wire

// >>> src/ppi_pkg.sv
// Shared constants and types for the third-port handshake and bit-control block
`default_nettype none
package ppi_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets (byte addresses on APB)
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_PORTC = 8'h04;
	localparam logic [7:0] OFF_BITSR = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFF_PORTA = 8'h14;
	localparam logic [7:0] OFF_PORTB = 8'h18;
	localparam int OFF_W = 8;

	////////////////////////////////////////////////////////////////////////////
	// Mode register layout, MSB first
	typedef struct packed {
		logic cl_input;     // Lower third-port nibble is input
		logic b_port_input; // Second group data port is input
		logic b_strobed;    // Second group in strobed mode
		logic cu_input;     // Upper third-port nibble is input
		logic a_port_input; // First group data port is input
		logic [1:0] a_mode; // 0 basic, 1 strobed, 2 or 3 bidirectional
	} mode_t;
	localparam int MODE_W = 7;
	localparam logic [6:0] MODE_RST = 7'h6C;
	localparam logic [1:0] A_MODE_BASIC = 2'h0;
	localparam logic [1:0] A_MODE_STROBED = 2'h1;
	localparam int A_MODE_BIDIR_BIT = 1;

	////////////////////////////////////////////////////////////////////////////
	// Third-port line positions
	localparam int PC_REQ_B = 0;
	localparam int PC_FULL_B = 1;
	localparam int PC_STROBE_ACK_B = 2;
	localparam int PC_REQ_A = 3;
	localparam int PC_STROBE_A = 4;
	localparam int PC_IN_FULL_A = 5;
	localparam int PC_ACK_A = 6;
	localparam int PC_OUT_FULL_A = 7;

	// Bit set/reset command fields
	localparam int BSR_VAL = 0;
	localparam int BSR_SEL_LO = 1;
	localparam int BSR_SEL_HI = 3;

	// Sticky event bits
	localparam int IRQ_W = 4;
	localparam int EV_REQ_A = 0;
	localparam int EV_REQ_B = 1;
	localparam int EV_FULL_A = 2;
	localparam int EV_FULL_B = 3;

	////////////////////////////////////////////////////////////////////////////
	// Bus slave states and handshake force targets
	typedef enum logic [0:0] {
		AP_IDLE = 1'h0,
		AP_DONE = 1'h1
	} apb_state_t;

	typedef enum logic [2:0] {
		FRC_NONE = 3'h0,
		FRC_REQ = 3'h1,
		FRC_IN_FULL = 3'h2,
		FRC_OUT_FULL = 3'h3,
		FRC_IE_IN = 3'h4,
		FRC_IE_OUT = 3'h5
	} frc_t;

	// Handshake group state
	typedef struct packed {
		logic input_latch_full;
		logic output_latch_full_n;
		logic service_request_out;
		logic in_irq_enable;
		logic out_irq_enable;
		logic in_cond_q;
		logic out_cond_q;
	} hs_state_t;
	localparam logic [6:0] HS_RST = 7'h20;

endpackage
`default_nettype wire
